/* src/bio_consts.svh */
// Address map, reset divisors and framing constants of the board I/O block
`ifndef BIO_CONSTS_SVH
`define BIO_CONSTS_SVH
// Port address fields, compared against the upper address bits; BIO_CTR_CTL against the low two bits
`define BIO_PIO_BASE   7'h7C
`define BIO_IOC_BASE   6'h30
`define BIO_CTR_BASE   6'h3C
`define BIO_SER_BASE   6'h3D
`define BIO_PIC_BASE   6'h3A
`define BIO_CTR_CTL    2'h3
// Memory accepted only below 64k: upper address bits all zero
`define BIO_MEM_HI_ZERO 4'h0
// Initial counter divisors for channel 0, channel 1 and the tick
`define BIO_DIV0       16'h02BA
`define BIO_DIV1       16'h0020
`define BIO_DIV2       16'h04CD
// Async framing: start + 8 data + 2 stop, 16X clock factor
`define BIO_TX_BITS    4'hB
`define BIO_RX_BITS    3'h7
`define BIO_X16_LAST   4'hF
`define BIO_X16_HALF   4'h7
// Command byte fields
`define BIO_CMD_EOI    7
`define BIO_CMD_SYNC   0
`define BIO_CASCADE    7
`endif

/* src/bio_pkg.sv */
// Types shared by the board I/O block
package bio_pkg;
    typedef enum logic [1:0] {BIO_RX_IDLE, BIO_RX_START, BIO_RX_DATA,
                              BIO_RX_STOP} bio_rx_t;
    typedef logic [7:0] bio_byte_t;
endpackage

/* src/bio_subsys.sv */
// Board I/O subsystem: port decode, counters, serial channels, interrupts
// Notes on behaviour
// RULE1: Accept bus memory only below 64k.
// RULE2: Bus memory boards must meet bus timing.
// RULE3: External port match enables shared data lines.
// RULE4: External match selects exactly one processor.
// RULE5: Each internal port gives a distinct chip select.
// RULE6: Command write, status read, data read/write.
// RULE7: Two serial, counters, two interrupt controllers.
// RULE8: Channel zero async, seven bits plus parity.
// RULE9: Sync mode; jumper picks internal/external clock.
// RULE10: Status byte shows transfer state, errors.
// RULE11: Default async, two stops, 8 bits, 16X.
// RULE12: Channel zero clock divisor gives 110 baud.
// RULE13: Channel one clock gives 2400 baud.
// RULE14: Three counters: two baud, one tick.
// RULE15: Counters run square wave, two-byte load.
// RULE16: Divisors 698, 32 and 1229 at start.
// RULE17: Counter content returned on command.
// RULE18: Eight lines, zero highest, masked.
// RULE19: Panel switch and bus requests alike.
// RULE20: Line seven reserved for local controller.
// RULE21: Fully nested, only higher preempts.
// RULE22: Local lines: serial, tick, PARALLEL_IO_PROCESSOR, IO_CONTROLLER_PROCESSOR.
// RULE23: Local controller behaves like system one.
// RULE24: Any local request raises cascade request; the code raises it only for an unmasked request above any in service.
// RULE25: Ports F8, F9 select parallel processor.
// RULE26: Ports C0 to C3 select I/O controller.
// RULE27: Counters share one reference tick.
// RULE28: Serial ready flags raise local requests.
`timescale 1ns/1ps
`include "bio_consts.svh"
module bio_subsys #(
    parameter int NCH = 2,
    parameter int NCTR = 3
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic [7:0]       io_addr,
    input  wire logic             io_rd,
    input  wire logic             io_wr,
    input  wire bio_pkg::bio_byte_t io_wdata,
    input  wire logic             mem_req,
    input  wire logic [19:0]      mem_addr,
    input  wire logic             ref_tick,
    input  wire logic [6:0]       panel_irq,
    input  wire logic [6:0]       bus_irq,
    input  wire logic             pio_done,
    input  wire logic             ioc_done,
    input  wire logic [NCH-1:0]   ser_rxd,
    input  wire logic [NCH-1:0]   ext_baud,
    input  wire logic [NCH-1:0]   ext_baud_sel,
    input  wire logic             sys_ack,
    input  wire logic             loc_ack,
    output bio_pkg::bio_byte_t    io_rdata,
    output logic                  ext_data_en,
    output logic                  parallel_proc_select_n,
    output logic                  io_ctrl_select_n,
    output logic [4:0]            chip_sel,
    output logic                  mem_accept,
    output logic [NCH-1:0]        ser_txd,
    output logic                  rtc_tick,
    output logic                  sys_int,
    output logic [2:0]            int_id
);
    import bio_pkg::*;

    // ======================================================
    // Port decode
    logic       acc, hit_pio, hit_ioc, hit_ctr, hit_ser, hit_pic;
    logic [4:0] sel_d;
    assign acc     = io_rd | io_wr;
    assign hit_pio = acc && io_addr[7:1] == `BIO_PIO_BASE;      // [RULE25]
    assign hit_ioc = acc && io_addr[7:2] == `BIO_IOC_BASE;      // [RULE26]
    assign hit_ctr = acc && io_addr[7:2] == `BIO_CTR_BASE;
    assign hit_ser = acc && io_addr[7:2] == `BIO_SER_BASE;
    assign hit_pic = acc && io_addr[7:2] == `BIO_PIC_BASE;
    // One select per on-board chip; bit 0 of the address picks command on the serial and interrupt chips
    assign sel_d = {hit_pic & io_addr[1], hit_pic & ~io_addr[1], hit_ctr,
                    hit_ser & io_addr[1], hit_ser & ~io_addr[1]}; // [RULE5]

    // Selects are registered so the outputs never glitch on address skew
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            parallel_proc_select_n <= 1'b1;
            io_ctrl_select_n       <= 1'b1;
            ext_data_en            <= 1'b0;
            chip_sel               <= 5'h00;
        end else if (clk_en) begin
            parallel_proc_select_n <= ~hit_pio;                 // [RULE4]
            io_ctrl_select_n       <= ~hit_ioc;                 // [RULE4]
            ext_data_en            <= hit_pio | hit_ioc;        // [RULE3]
            chip_sel               <= sel_d;                    // [RULE5]
        end
    end

    // Bus memory window check
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) mem_accept <= 1'b0;
        else if (clk_en)
            mem_accept <= mem_req &&
                          mem_addr[19:16] == `BIO_MEM_HI_ZERO;  // [RULE1]
    end

    // ======================================================
    // Counters: all decrement on the shared reference tick [RULE7]
    localparam logic [15:0] DIV_RST [3] = '{`BIO_DIV0, `BIO_DIV1,
                                            `BIO_DIV2}; // [RULE13]
    logic [15:0]     cnt_q [NCTR];
    logic [15:0]     div_q [NCTR];
    logic [15:0]     lat_q [NCTR];
    logic [NCTR-1:0] out_q, lat_v_q, wr_hi_q, rd_hi_q;
    logic [7:0]      lo_q  [NCTR];
    logic            ctl_wr;
    assign ctl_wr = hit_ctr && io_wr && io_addr[1:0] == `BIO_CTR_CTL;
    genvar c;
    generate
        for (c = 0; c < NCTR; c++) begin : g_ctr
            logic wr_me, rd_me, ctl_me;
            assign wr_me  = hit_ctr && io_wr && io_addr[1:0] == 2'(c);
            assign rd_me  = hit_ctr && io_rd && io_addr[1:0] == 2'(c);
            assign ctl_me = ctl_wr && io_wdata[7:6] == 2'(c);
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    cnt_q[c]   <= DIV_RST[c];                   // [RULE16]
                    div_q[c]   <= DIV_RST[c];                   // [RULE16]
                    out_q[c]   <= 1'b1;
                    lo_q[c]    <= 8'h00;
                    wr_hi_q[c] <= 1'b0;
                end else if (clk_en) begin
                    // Low byte first, divisor takes effect on high byte
                    if (wr_me && !wr_hi_q[c]) begin
                        lo_q[c]    <= io_wdata;                 // [RULE15]
                        wr_hi_q[c] <= 1'b1;
                    end else if (wr_me) begin
                        div_q[c]   <= {io_wdata, lo_q[c]};      // [RULE15]
                        cnt_q[c]   <= {io_wdata, lo_q[c]};
                        wr_hi_q[c] <= 1'b0;
                    end else if (ref_tick) begin                // [RULE27]
                        // Square wave: high for the upper half count
                        cnt_q[c] <= (cnt_q[c] <= 16'h0001) ? div_q[c]
                                    : cnt_q[c] - 16'h0001;      // [RULE15]
                        out_q[c] <= cnt_q[c] > {1'b0, div_q[c][15:1]};
                    end
                end
            end
            // Latch command freezes a copy; reads give low then high
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    lat_q[c]   <= 16'h0000;
                    lat_v_q[c] <= 1'b0;
                    rd_hi_q[c] <= 1'b0;
                end else if (clk_en) begin
                    if (ctl_me && io_wdata[5:4] == 2'h0) begin
                        lat_q[c]   <= cnt_q[c];                 // [RULE17]
                        lat_v_q[c] <= 1'b1;
                    end
                    if (rd_me) begin
                        rd_hi_q[c] <= ~rd_hi_q[c];
                        if (rd_hi_q[c]) lat_v_q[c] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) rtc_tick <= 1'b1;
        else if (clk_en) rtc_tick <= out_q[2];                  // [RULE14]
    end

    // ======================================================
    // Serial channels, async 11-bit frames; sync mode drops the 16X factor
    logic [NCH-1:0] tx_rdy, rx_rdy_q;
    logic [7:0]     rx_buf_q [NCH];
    logic [7:0]     stat     [NCH];
    genvar s;
    generate
        for (s = 0; s < NCH; s++) begin : g_ser
            bio_rx_t     rx_st_q;
            logic        sync_q, src_q, btick, tick16, ferr_q, oerr_q;
            logic        src, cmd_wr, dat_wr, dat_rd, rx_done;
            logic [3:0]  sub_q, tx_cnt_q, rph_q;
            logic [10:0] tx_sh_q;
            logic [7:0]  rx_sh_q;
            logic [2:0]  rx_bit_q;
            assign cmd_wr = sel_d[s] && io_wr && io_addr[0];    // [RULE6]
            assign dat_wr = sel_d[s] && io_wr && !io_addr[0];
            assign dat_rd = sel_d[s] && io_rd && !io_addr[0];
            // Jumper picks the counter output or an external bit clock
            assign src    = ext_baud_sel[s] ? ext_baud[s] : out_q[s]; // [RULE9]
            assign btick  = src & ~src_q;
            assign tick16 = btick && (sync_q || sub_q == `BIO_X16_LAST);
            assign tx_rdy[s] = tx_cnt_q == 4'h0;
            assign rx_done = btick && rx_st_q == BIO_RX_STOP &&
                             (sync_q || rph_q == `BIO_X16_LAST);
            assign stat[s] = {4'h0, ferr_q, oerr_q, rx_rdy_q[s], tx_rdy[s]};
            // Mode register and transmitter
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync_q     <= 1'b0;                         // [RULE11]
                    src_q      <= 1'b0;
                    sub_q      <= 4'h0;
                    tx_cnt_q   <= 4'h0;
                    tx_sh_q    <= 11'h7FF;
                    ser_txd[s] <= 1'b1;
                end else if (clk_en) begin
                    src_q <= src;
                    if (cmd_wr) sync_q <= io_wdata[`BIO_CMD_SYNC]; // [RULE9]
                    if (btick) sub_q <= sub_q + 4'h1;           // [RULE12]
                    if (dat_wr && tx_rdy[s]) begin
                        tx_sh_q  <= {2'b11, io_wdata, 1'b0};    // [RULE11]
                        tx_cnt_q <= `BIO_TX_BITS;
                    end else if (tick16 && !tx_rdy[s]) begin
                        ser_txd[s] <= tx_sh_q[0];
                        tx_sh_q    <= {1'b1, tx_sh_q[10:1]};
                        tx_cnt_q   <= tx_cnt_q - 4'h1;
                    end
                end
            end
            // Receiver: centre the start bit, then sample each bit time
            // Seven bits plus parity arrive as the 8 data bits of one frame [RULE8]
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    rx_st_q  <= BIO_RX_IDLE;
                    rph_q    <= 4'h0;
                    rx_bit_q <= 3'h0;
                    rx_sh_q  <= 8'h00;
                end else if (clk_en) begin
                    if (btick) rph_q <= rph_q + 4'h1;
                    case (rx_st_q)
                        BIO_RX_IDLE: if (!ser_rxd[s]) begin
                            rx_st_q <= BIO_RX_START;
                            rph_q   <= 4'h0;
                        end
                        BIO_RX_START: if (btick && (sync_q ||
                                rph_q == `BIO_X16_HALF)) begin
                            rx_st_q  <= ser_rxd[s] ? BIO_RX_IDLE
                                                   : BIO_RX_DATA;
                            rph_q    <= 4'h0;
                            rx_bit_q <= 3'h0;
                        end
                        BIO_RX_DATA: if (btick && (sync_q ||
                                rph_q == `BIO_X16_LAST)) begin
                            rx_sh_q  <= {ser_rxd[s], rx_sh_q[7:1]};
                            rx_bit_q <= rx_bit_q + 3'h1;
                            if (rx_bit_q == `BIO_RX_BITS)
                                rx_st_q <= BIO_RX_STOP;
                        end
                        BIO_RX_STOP: if (rx_done) rx_st_q <= BIO_RX_IDLE;
                        default: rx_st_q <= BIO_RX_IDLE;
                    endcase
                end
            end
            // Ready and error flags; a new character beats a read clear
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    rx_rdy_q[s] <= 1'b0;
                    rx_buf_q[s] <= 8'h00;
                    ferr_q      <= 1'b0;
                    oerr_q      <= 1'b0;
                end else if (clk_en) begin
                    if (cmd_wr) begin
                        ferr_q <= 1'b0;
                        oerr_q <= 1'b0;
                    end
                    if (rx_done) begin
                        rx_buf_q[s] <= rx_sh_q;
                        rx_rdy_q[s] <= 1'b1;                    // [RULE28]
                        ferr_q      <= ~ser_rxd[s];             // [RULE10]
                        oerr_q      <= rx_rdy_q[s] & ~dat_rd;   // [RULE10]
                    end else if (dat_rd) rx_rdy_q[s] <= 1'b0;
                end
            end
        end
    endgenerate

    // ======================================================
    // Interrupt controllers: index 0 system, index 1 local
    logic [7:0] req [2];
    logic [7:0] mask_q [2];
    logic [7:0] isr_q  [2];
    logic [1:0] pic_int;
    logic       cascade_request;
    assign cascade_request = pic_int[1];                        // [RULE24]
    // Panel switches and bus lines are merged without distinction
    // Line 7 is kept for the local controller alone [RULE20]
    assign req[0] = {cascade_request, panel_irq | bus_irq};     // [RULE19]
    assign req[1] = {1'b0, ioc_done, pio_done, out_q[2],        // [RULE22]
                     tx_rdy[1], rx_rdy_q[1], tx_rdy[0], rx_rdy_q[0]};

    // Lowest set index wins; bit 3 flags that any bit was set
    function automatic logic [3:0] bio_prio(input logic [7:0] v);
        bio_prio = 4'h0;
        for (int i = 7; i >= 0; i--)
            if (v[i]) bio_prio = {1'b1, 3'(i)};
    endfunction

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pic
            logic [3:0] top_req, top_isr;
            logic       ack, cmd_wr, dat_wr;
            assign top_req = bio_prio(req[p] & ~mask_q[p]);     // [RULE18]
            assign top_isr = bio_prio(isr_q[p]);
            assign ack     = p == 0 ? sys_ack : loc_ack;
            assign cmd_wr  = sel_d[3+p] && io_wr && io_addr[0];
            assign dat_wr  = sel_d[3+p] && io_wr && !io_addr[0];
            // Only a strictly higher request preempts the one in service
            assign pic_int[p] = top_req[3] && (!top_isr[3] ||
                                top_req[2:0] < top_isr[2:0]); // [RULE21] [RULE23]
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    mask_q[p] <= 8'h00;
                    isr_q[p]  <= 8'h00;
                end else if (clk_en) begin
                    if (dat_wr) mask_q[p] <= io_wdata;          // [RULE18]
                    if (ack && pic_int[p])
                        isr_q[p][top_req[2:0]] <= 1'b1;         // [RULE21]
                    else if (cmd_wr && io_wdata[`BIO_CMD_EOI] && top_isr[3])
                        isr_q[p][top_isr[2:0]] <= 1'b0;
                end
            end
        end
    endgenerate

    // Interrupt line and identity of the last acknowledged request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_int <= 1'b0;
            int_id  <= 3'h0;
        end else if (clk_en) begin
            sys_int <= pic_int[0];
            if (sys_ack && pic_int[0]) int_id <= g_pic[0].top_req[2:0];
            else if (loc_ack && pic_int[1])
                int_id <= g_pic[1].top_req[2:0];
        end
    end

    // ======================================================
    // Read data: command port gives status, data port gives data
    bio_byte_t rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        if (hit_ser && io_rd)
            rdata_d = io_addr[0] ? stat[io_addr[1]]            // [RULE10]
                                 : rx_buf_q[io_addr[1]];
        else if (hit_ctr && io_rd && io_addr[1:0] != `BIO_CTR_CTL) begin
            rdata_d = rd_hi_q[io_addr[1:0]]
                ? (lat_v_q[io_addr[1:0]] ? lat_q[io_addr[1:0]][15:8]
                                         : cnt_q[io_addr[1:0]][15:8])
                : (lat_v_q[io_addr[1:0]] ? lat_q[io_addr[1:0]][7:0]
                                         : cnt_q[io_addr[1:0]][7:0]);
        end else if (hit_pic && io_rd)
            rdata_d = io_addr[0] ? isr_q[io_addr[1]] : mask_q[io_addr[1]];
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) io_rdata <= 8'h00;
        else if (clk_en) io_rdata <= rdata_d;                   // [RULE6]
    end

    // ======================================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_pio_sel;
        clk_en && hit_pio |=> !parallel_proc_select_n && ext_data_en;
    endproperty
    a_pio_sel: assert property (p_pio_sel) else $error("pio select"); // [RULE25]
    property p_ioc_sel;
        clk_en && hit_ioc |=> !io_ctrl_select_n && ext_data_en;
    endproperty
    a_ioc_sel: assert property (p_ioc_sel) else $error("ioc select"); // [RULE26]
    property p_one_ext;
        !(parallel_proc_select_n == 1'b0 && io_ctrl_select_n == 1'b0);
    endproperty
    a_one_ext: assert property (p_one_ext) else $error("both selects"); // [RULE4]
    property p_ext_en;
        ext_data_en == (!parallel_proc_select_n || !io_ctrl_select_n);
    endproperty
    a_ext_en: assert property (p_ext_en) else $error("ext enable"); // [RULE3]
    property p_mem;
        clk_en ##1 mem_accept |-> $past(mem_addr[19:16]) == 4'h0;
    endproperty
    a_mem: assert property (p_mem) else $error("memory above 64k"); // [RULE1]
    property p_cascade;
        pic_int[1] |-> req[0][`BIO_CASCADE];
    endproperty
    a_cascade: assert property (p_cascade) else $error("no cascade"); // [RULE24]
    property p_tx_busy;
        clk_en && g_ser[0].dat_wr && tx_rdy[0] |=> !tx_rdy[0];
    endproperty
    a_tx_busy: assert property (p_tx_busy) else $error("tx not busy"); // [RULE28]
    property p_ctr_reload;
        clk_en && ref_tick && !g_ctr[0].wr_me && cnt_q[0] == 16'h0001
            |=> cnt_q[0] == div_q[0];
    endproperty
    a_ctr_reload: assert property (p_ctr_reload) else $error("reload"); // [RULE15]
    c_sys_ack: cover property (sys_ack && pic_int[0]);
    c_rx_done: cover property (rx_rdy_q[0]);
    c_latch:   cover property (ctl_wr ##1 lat_v_q != 3'h0);
endmodule

/* verif/bio_ser_dev.sv */
// Serial device model feeding one receive line with its own bit clock
`timescale 1ns/1ps
module bio_ser_dev (
    input  wire logic       clk,
    input  wire logic       start,
    input  wire logic [7:0] data,
    output logic            baud,
    output logic            rxd,
    output logic            busy
);
    // Line idles high and the bit clock stands still between frames
    initial begin
        baud = 1'b0;
        rxd  = 1'b1;
        busy = 1'b0;
    end
    // Start, 8 data LSB first, 2 stops; 16 baud pulses of 8 clock cycles each per bit
    always @(posedge clk) begin
        if (start && !busy) begin
            busy = 1'b1;
            for (int i = 0; i < 11; i++) begin
                #1 rxd = ({2'b11, data, 1'b0} >> i) & 11'h001;
                repeat (16) begin
                    repeat (4) @(posedge clk);
                    #1 baud = 1'b1;
                    repeat (4) @(posedge clk);
                    #1 baud = 1'b0;
                end
            end
            busy = 1'b0;
        end
    end
endmodule

/* verif/bio_subsys_tb.sv */
// Self-checking testbench of the board I/O subsystem
`timescale 1ns/1ps
module bio_subsys_tb;
    import bio_pkg::*;
    logic       clk, reset_n, io_rd, io_wr, mem_req, sys_ack, start, busy;
    logic       baud0, rxd0, ext_data_en, pio_n, ioc_n, mem_accept, rtc_tick;
    logic       sys_int, pio_done, ioc_done;
    logic [7:0] io_addr;
    bio_byte_t  io_wdata, io_rdata, rd, lo;
    logic [19:0] mem_addr;
    logic [6:0] panel_irq, bus_irq;
    logic [4:0] chip_sel;
    logic [1:0] ser_txd;
    logic [2:0] int_id;
    int         errors = 0, cmp_count = 0;
    bio_byte_t  adr[10] = '{8'hF8, 8'hF9, 8'hC0, 8'hC1, 8'hC2, 8'hC3,
                            8'hF3, 8'hF4, 8'hE8, 8'hC4};
    bio_byte_t  exd[10] = '{8'hA0, 8'hA0, 8'hC0, 8'hC0, 8'hC0, 8'hC0,
                            8'h64, 8'h61, 8'h68, 8'h60};
    logic [15:0] div[3] = '{16'h02BA, 16'h0020, 16'h04CD};
    // ==========================================================
    // Clock, design and far-side serial device
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    bio_subsys bio_subsys_i (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
        .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .mem_req(mem_req), .mem_addr(mem_addr), .ref_tick(1'b0),
        .panel_irq(panel_irq), .bus_irq(bus_irq), .pio_done(pio_done),
        .ioc_done(ioc_done), .ser_rxd({1'b1, rxd0}), .ext_baud({1'b0, baud0}),
        .ext_baud_sel(2'b01), .sys_ack(sys_ack), .loc_ack(1'b0),
        .io_rdata(io_rdata), .ext_data_en(ext_data_en),
        .parallel_proc_select_n(pio_n), .io_ctrl_select_n(ioc_n),
        .chip_sel(chip_sel), .mem_accept(mem_accept), .ser_txd(ser_txd),
        .rtc_tick(rtc_tick), .sys_int(sys_int), .int_id(int_id));
    bio_ser_dev bio_ser_dev_i (.clk(clk), .start(start), .data(8'hA5),
        .baud(baud0), .rxd(rxd0), .busy(busy));
    // ==========================================================
    // Port bus tasks: strobe held through the sampling edge
    task automatic io_write(input bio_byte_t a, input bio_byte_t d);
        @(posedge clk);
        #1 {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
        @(posedge clk);
        #1 io_wr = 1'b0;
    endtask
    task automatic io_read(input bio_byte_t a);
        @(posedge clk);
        #1 {io_addr, io_rd} = {a, 1'b1};
        @(posedge clk);
        #1 io_rd = 1'b0;
        rd = io_rdata;
    endtask
    task automatic ack();
        @(posedge clk);
        #1 sys_ack = 1'b1;
        @(posedge clk);
        #1 sys_ack = 1'b0;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for the interrupt output, then compare it
    task automatic wait_int(input logic e);
        for (int i = 0; i < 10; i++) begin
            if (sys_int === e) break;
            @(posedge clk);
            #1;
        end
        chk(sys_int, e);
    endtask
    task automatic end_sim();
        if (errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Watchdog well beyond one serial frame plus the short tests
    initial begin
        #200000;
        errors++;
        end_sim();
    end
    // ==========================================================
    // Test sequence
    initial begin
        {reset_n, io_rd, io_wr, mem_req, sys_ack, start} = 6'h00;
        {io_addr, io_wdata, mem_addr, panel_irq, bus_irq} = '0;
        {pio_done, ioc_done} = 2'b00;
        repeat (3) @(posedge clk);
        #1 reset_n = 1'b1;
        chk({rtc_tick, ser_txd, pio_n, ioc_n, chip_sel}, 16'h03E0);
        // Decode table, unmapped C4 gives no select
        for (int k = 0; k < 10; k++) begin
            io_read(adr[k]);
            chk({ext_data_en, pio_n, ioc_n, chip_sel}, exd[k]);
        end
        chk(rd, 8'h00);
        // Memory below 64k accepted only
        #1 {mem_req, mem_addr} = {1'b1, 20'h0FFFF};
        @(posedge clk);
        #1 chk(mem_accept, 1'b1);
        mem_addr = 20'h10000;
        @(posedge clk);
        #1 chk(mem_accept, 1'b0);
        // Latched counter contents equal the start divisors
        for (int k = 0; k < 3; k++) begin
            io_write(8'hF3, bio_byte_t'(k << 6));
            io_read(bio_byte_t'(8'hF0 + k));
            lo = rd;
            io_read(bio_byte_t'(8'hF0 + k));
            chk({rd, lo}, div[k]);
        end
        // Transmit ready and the idle-high tick output cascade to system line 7
        wait_int(1'b1);
        // Tick output idles high after reset, so line 4 is masked too
        io_write(8'hEA, 8'h1F);
        wait_int(1'b0);
        #1 pio_done = 1'b1;
        wait_int(1'b1);
        #1 pio_done = 1'b0;
        wait_int(1'b0);
        #1 ioc_done = 1'b1;
        wait_int(1'b1);
        #1 ioc_done = 1'b0;
        // Nested priority: line 3 then higher line 1 preempts
        #1 bus_irq = 7'h08;
        wait_int(1'b1);
        ack();
        chk(int_id, 3'h3);
        wait_int(1'b0);
        #1 panel_irq = 7'h02;
        wait_int(1'b1);
        ack();
        chk(int_id, 3'h1);
        // Mask lines 1 and 3 so neither pending request returns
        io_write(8'hE8, 8'h0A);
        io_write(8'hE9, 8'h80);
        io_write(8'hE9, 8'h80);
        wait_int(1'b0);
        {panel_irq, bus_irq} = '0;
        io_write(8'hE8, 8'h00);
        io_write(8'hEA, 8'h00);
        wait_int(1'b1);
        ack();
        chk(int_id, 3'h7);
        // Transmitter busy after a data write
        io_write(8'hF4, 8'h3C);
        io_read(8'hF5);
        chk(rd[0], 1'b0);
        // Receive one frame from the device
        #1 start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        @(posedge clk);
        for (int i = 0; i < 3000 && busy; i++) @(posedge clk);
        repeat (4) @(posedge clk);
        io_read(8'hF5);
        chk(rd[1], 1'b1);
        io_read(8'hF4);
        chk(rd, 8'hA5);
        io_read(8'hF5);
        chk(rd[1], 1'b0);
        end_sim();
    end
endmodule
